// >>> src/cms_status.sv
// Purpose: cycle measurement timer channel with its status flags
// Assumes: event and external clock pins synchronous to clk_in (10 MHz)
// Notes:   read data appear the cycle after the read strobe
// Function
// - In speed mode the limit flag sets when the new capture exceeds the limit value.
// - A flag clears only by reading it as 1 and then writing 0; writing 1 never sets it.
// - In timer mode the match flag sets whenever the run bit is set and the counter equals the limit value.
// - In speed mode the match flag never sets.
// - The external edge select bit acts only when clock source select is 3'b111.
// - With the external clock the counter counts falling edges for 0 and rising for 1.
// - In timer mode, while the run bit is set, the selected event edge copies the counter and sets the capture flag.
// - In speed mode the third selected edge copies the counter and sets the capture flag.
// - A measurement period spans two event periods and the limit check uses that count.
// - Status bits 2 to 0 are reserved, read zero and ignore writes.
// - Mode select 0 is timer mode and 1 is speed measurement mode.
// - Capture edge is rising for 0, falling for 1, inverted by polarity reversal.
// - The wrap flag sets when the counter rolls from its maximum to zero.
//
// Implementation choices: the address-and-strobe port and the address map.
`default_nettype none
module cms_status
  import cms_pkg::*;
#(
  parameter int DATA_W = CMS_DATA_W,
  parameter int PRE_W  = CMS_PRE_W
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic [CMS_ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0]     wr_data_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  input  wire logic                  event_input_in,
  input  wire logic                  ext_clock_in,
  output logic      [DATA_W-1:0]     rd_data_out,
  output logic      [7:0]            measure_status_out
);
  logic [7:0]        status_ff;
  logic [7:0]        nxt_status;
  logic [7:0]        control_ff;
  logic [15:0]       limit_compare_value_ff;
  logic [15:0]       capture_value_ff;
  logic [15:0]       cycle_counter_ff;
  logic [15:0]       nxt_counter;
  logic [PRE_W-1:0]  prescale_ff;
  logic [7:0]        clear_armed_ff;
  logic [DATA_W-1:0] rd_data_ff;
  cms_meas_t         meas_state_ff;
  cms_meas_t         nxt_meas_state;

  logic              speed_mode;
  logic              run;
  logic              stop_on_limit;
  logic [2:0]        clock_source_sel;
  logic              ext_clock_edge_sel;
  logic              capture_edge_fall;
  logic              event_edge;
  logic              ext_edge;
  logic              int_tick;
  logic              tick;
  logic              halted;
  logic              cap_now;
  logic              limit_set;
  logic              match_set;
  logic              wrap_set;
  logic              status_wr;
  logic [PRE_W-1:0]  pre_mask;
  logic [PRE_W:0]    pre_mask_wide;

  assign speed_mode         = control_ff[CMS_CT_MODE];
  assign run                = control_ff[CMS_CT_RUN];
  assign stop_on_limit      = control_ff[CMS_CT_STOP_EN];
  assign clock_source_sel   = control_ff[CMS_CT_CKS_LO +: 3];
  assign ext_clock_edge_sel = status_ff[CMS_ST_EXT_EDGE];
  // polarity reversal flips the edge choice
  assign capture_edge_fall  = control_ff[CMS_CT_CAP_EDGE] ^ control_ff[CMS_CT_POL_INV];
  assign status_wr          = wr_in && (addr_in == CMS_OFF_STATUS);

  cms_edge_det u_event_edge (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .sig_in      (event_input_in),
    .fall_sel_in (capture_edge_fall),
    .edge_out    (event_edge)
  );

  // sel 0 counts falling edges, so fall select is the inverse of the bit
  cms_edge_det u_ext_edge (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .sig_in      (ext_clock_in),
    .fall_sel_in (~ext_clock_edge_sel),
    .edge_out    (ext_edge)
  );

  // internal sources divide by 2, 8, 32 ... as sel grows
  always_comb begin
    pre_mask_wide = ({{PRE_W{1'b0}}, 1'b1} << (6'(clock_source_sel) * 6'd2 + 6'd1))
                    - {{PRE_W{1'b0}}, 1'b1};
    pre_mask      = pre_mask_wide[PRE_W-1:0];
    int_tick      = ((prescale_ff & pre_mask) == pre_mask);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prescale_ff <= '0;
    end else begin
      prescale_ff <= prescale_ff + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // edge select only matters once the external source is chosen
  always_comb begin
    if (clock_source_sel == CMS_CKS_EXTERNAL) begin
      tick = ext_edge;
    end else begin
      tick = int_tick;
    end
  end

  // speed mode can freeze after a limit overflow when enabled
  assign halted = speed_mode && stop_on_limit && status_ff[CMS_ST_LIMIT];

  // measurement period: first edge clears, second passes, third captures
  always_comb begin
    nxt_meas_state = meas_state_ff;
    cap_now        = 1'b0;
    if (!speed_mode) begin
      nxt_meas_state = CMS_MEAS_IDLE;
      cap_now        = run && event_edge;
    end else if (event_edge && !halted) begin
      unique case (meas_state_ff)
        CMS_MEAS_IDLE:   nxt_meas_state = CMS_MEAS_FIRST;
        CMS_MEAS_FIRST:  nxt_meas_state = CMS_MEAS_SECOND;
        CMS_MEAS_SECOND: begin
          // third edge closes two event periods and opens the next span
          nxt_meas_state = CMS_MEAS_FIRST;
          cap_now        = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meas_state_ff <= CMS_MEAS_IDLE;
    end else begin
      meas_state_ff <= nxt_meas_state;
    end
  end

  always_comb begin
    nxt_counter = cycle_counter_ff;
    wrap_set    = 1'b0;
    if (!speed_mode) begin
      if (!run) begin
        nxt_counter = CMS_COUNT_RST;
      end else if (wr_in && addr_in == CMS_OFF_COUNTER) begin
        nxt_counter = wr_data_in[15:0];
      end else if (tick) begin
        nxt_counter = cycle_counter_ff + 16'h0001;
        wrap_set    = (cycle_counter_ff == CMS_COUNT_MAX);
      end
    end else if (halted) begin
      nxt_counter = cycle_counter_ff;
    end else if (event_edge && meas_state_ff != CMS_MEAS_FIRST) begin
      // restart of a span: count starts again from zero
      nxt_counter = CMS_COUNT_RST;
    end else if (tick && meas_state_ff != CMS_MEAS_IDLE) begin
      nxt_counter = cycle_counter_ff + 16'h0001;
      wrap_set    = (cycle_counter_ff == CMS_COUNT_MAX);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cycle_counter_ff <= CMS_COUNT_RST;
    end else begin
      cycle_counter_ff <= nxt_counter;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      capture_value_ff <= CMS_COUNT_RST;
    end else if (cap_now) begin
      capture_value_ff <= cycle_counter_ff;
    end
  end

  // limit check uses the count being captured, not the old capture
  assign limit_set = speed_mode && cap_now
                     && (cycle_counter_ff > limit_compare_value_ff);
  assign match_set = !speed_mode && run
                     && (cycle_counter_ff == limit_compare_value_ff);

  // a flag read as 1 arms its clear; the arm drops on any status write
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      clear_armed_ff <= 8'h00;
    end else if (status_wr) begin
      clear_armed_ff <= 8'h00;
    end else if (rd_in && addr_in == CMS_OFF_STATUS) begin
      clear_armed_ff <= clear_armed_ff | status_ff;
    end
  end

  always_comb begin
    nxt_status = status_ff;
    if (status_wr) begin
      nxt_status[CMS_ST_EXT_EDGE] = wr_data_in[CMS_ST_EXT_EDGE];
      for (int i = CMS_ST_CAPTURE; i <= CMS_ST_WRAP; i++) begin
        if (i != CMS_ST_EXT_EDGE && clear_armed_ff[i] && !wr_data_in[i]) begin
          nxt_status[i] = 1'b0;
        end
      end
    end
    // set terms come last so an event beats a clear in the same cycle
    if (wrap_set) begin
      nxt_status[CMS_ST_WRAP] = 1'b1;
    end
    if (limit_set) begin
      nxt_status[CMS_ST_LIMIT] = 1'b1;
    end
    if (match_set) begin
      nxt_status[CMS_ST_MATCH] = 1'b1;
    end
    if (cap_now) begin
      nxt_status[CMS_ST_CAPTURE] = 1'b1;
    end
    nxt_status[2:0] = 3'h0;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_ff <= CMS_STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      control_ff <= CMS_CONTROL_RST;
    end else if (wr_in && addr_in == CMS_OFF_CONTROL) begin
      control_ff <= wr_data_in[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      limit_compare_value_ff <= CMS_LIMIT_RST;
    end else if (wr_in && addr_in == CMS_OFF_LIMIT) begin
      limit_compare_value_ff <= wr_data_in[15:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_data_ff <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        CMS_OFF_STATUS:  rd_data_ff <= DATA_W'(status_ff);
        CMS_OFF_CONTROL: rd_data_ff <= DATA_W'(control_ff);
        CMS_OFF_LIMIT:   rd_data_ff <= DATA_W'(limit_compare_value_ff);
        CMS_OFF_CAPTURE: rd_data_ff <= DATA_W'(capture_value_ff);
        CMS_OFF_COUNTER: rd_data_ff <= DATA_W'(cycle_counter_ff);
        default:         rd_data_ff <= '0;
      endcase
    end else begin
      rd_data_ff <= '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      measure_status_out <= CMS_STATUS_RST;
    end else begin
      measure_status_out <= nxt_status;
    end
  end

  assign rd_data_out = rd_data_ff;
endmodule
`default_nettype wire

// >>> include/cms_pkg.sv
// Purpose: shared constants for the cycle measurement status block
// Assumes: 16-bit register word, registers indexed by small word offsets
// Notes:   offsets are word indices on the plain register port
`default_nettype none
package cms_pkg;
  localparam int          CMS_DATA_W       = 16;
  localparam int          CMS_ADDR_W       = 3;
  localparam int          CMS_PRE_W        = 13;

  // register offsets
  localparam logic [2:0]  CMS_OFF_STATUS   = 3'h0;
  localparam logic [2:0]  CMS_OFF_CONTROL  = 3'h1;
  localparam logic [2:0]  CMS_OFF_LIMIT    = 3'h2;
  localparam logic [2:0]  CMS_OFF_CAPTURE  = 3'h3;
  localparam logic [2:0]  CMS_OFF_COUNTER  = 3'h4;

  // measure_status field positions
  localparam int          CMS_ST_WRAP      = 7;
  localparam int          CMS_ST_LIMIT     = 6;
  localparam int          CMS_ST_MATCH     = 5;
  localparam int          CMS_ST_EXT_EDGE  = 4;
  localparam int          CMS_ST_CAPTURE   = 3;

  // measure_control field positions
  localparam int          CMS_CT_MODE      = 0;
  localparam int          CMS_CT_POL_INV   = 1;
  localparam int          CMS_CT_CAP_EDGE  = 2;
  localparam int          CMS_CT_CKS_LO    = 3;
  localparam int          CMS_CT_RUN       = 6;
  localparam int          CMS_CT_STOP_EN   = 7;

  localparam logic [2:0]  CMS_CKS_EXTERNAL = 3'h7;

  // reset values and the counter maximum
  localparam logic [7:0]  CMS_STATUS_RST   = 8'h00;
  localparam logic [7:0]  CMS_CONTROL_RST  = 8'h00;
  localparam logic [15:0] CMS_LIMIT_RST    = 16'hFFFF;
  localparam logic [15:0] CMS_COUNT_RST    = 16'h0000;
  localparam logic [15:0] CMS_COUNT_MAX    = 16'hFFFF;

  typedef enum logic [1:0] {
    CMS_MEAS_IDLE,
    CMS_MEAS_FIRST,
    CMS_MEAS_SECOND
  } cms_meas_t;
endpackage
`default_nettype wire

// >>> src/cms_edge_det.sv
// Purpose: rising or falling edge detect on a synchronous input
// Assumes: sig_in already synchronous to clk_in
// Notes:   fall_sel_in high picks falling edges, low picks rising edges
`default_nettype none
module cms_edge_det (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic sig_in,
  input  wire logic fall_sel_in,
  output logic      edge_out
);
  logic last_ff;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= sig_in;
    end
  end

  always_comb begin
    if (fall_sel_in) begin
      edge_out = last_ff & ~sig_in;
    end else begin
      edge_out = ~last_ff & sig_in;
    end
  end
endmodule
`default_nettype wire

// >>> dv/cms_tach_model.sv
// Purpose: fan tach source and external count clock for the status block
// Assumes: both lines change just after a rising clk_in edge
// Notes:   the tach line holds its level while stopped
`default_nettype none
module cms_tach_model #(
  parameter int HALF = 20
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic run_in,
  input  wire logic ext_lvl_in,
  output logic      event_out,
  output logic      ext_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_ff;
  // steady square wave, so every span is two equal periods
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cnt_ff <= 0;
      event_out <= 1'b0;
    end else if (run_in) begin
      cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff == HALF - 1)
        event_out <= ~event_out;
    end
  end
  always_ff @(posedge clk_in)
    ext_clk_out <= ext_lvl_in;
endmodule
`default_nettype wire

// >>> dv/cms_status_sva.sv
// Purpose: port checks on the status flags
// Assumes: one clock, synchronous active-low reset
// Notes:   mode and event age kept in helper logic
`default_nettype none
module cms_status_sva
  import cms_pkg::*;
#(
  parameter int DATA_W = CMS_DATA_W
) (
  input wire logic                  clk_in,
  input wire logic                  reset_n_in,
  input wire logic [CMS_ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0]     wr_data_in,
  input wire logic                  wr_in,
  input wire logic                  rd_in,
  input wire logic                  event_input_in,
  input wire logic [DATA_W-1:0]     rd_data_out,
  input wire logic [7:0]            measure_status_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       mode_ff;
  logic       ev_q_ff;
  logic [2:0] ev_age_ff;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  always_ff @(posedge clk_in) begin
    if (!reset_n_in)
      mode_ff <= 1'b0;
    else if (wr_in && addr_in == CMS_OFF_CONTROL)
      mode_ff <= wr_data_in[CMS_CT_MODE];
  end
  // cycles since the event pin last changed, saturating
  always_ff @(posedge clk_in) begin
    ev_q_ff <= event_input_in;
    if (!reset_n_in)
      ev_age_ff <= 3'h7;
    else if (event_input_in != ev_q_ff)
      ev_age_ff <= 3'h0;
    else if (ev_age_ff != 3'h7)
      ev_age_ff <= ev_age_ff + 3'h1;
  end
  property clr_p(int k);
    $fell(measure_status_out[k]) |->
      $past(wr_in) && $past(addr_in) == CMS_OFF_STATUS && !$past(wr_data_in[k]);
  endproperty
  wrap_clear_a: assert property (clr_p(CMS_ST_WRAP)) else $error("wrap flag lost");
  limit_clear_a: assert property (clr_p(CMS_ST_LIMIT)) else $error("limit flag lost");
  match_clear_a: assert property (clr_p(CMS_ST_MATCH)) else $error("match flag lost");
  cap_clear_a: assert property (clr_p(CMS_ST_CAPTURE)) else $error("capture flag lost");
  reserved_zero_a: assert property (measure_status_out[2:0] == 3'h0)
    else $error("reserved bits set");
  status_read_a: assert property ($past(rd_in) && $past(addr_in) == CMS_OFF_STATUS |->
    rd_data_out == {{(DATA_W-8){1'b0}}, $past(measure_status_out)}) else $error("bad status read");
  rd_idle_a: assert property (!$past(rd_in) |-> rd_data_out == '0) else $error("stray read data");
  speed_no_match_a: assert property (mode_ff && $past(mode_ff) |->
    !$rose(measure_status_out[CMS_ST_MATCH])) else $error("match set in speed mode");
  cap_cause_a: assert property ($rose(measure_status_out[CMS_ST_CAPTURE]) |->
    ev_age_ff <= 3'h3) else $error("capture without event edge");
  limit_with_cap_a: assert property ($rose(measure_status_out[CMS_ST_LIMIT]) |->
    measure_status_out[CMS_ST_CAPTURE]) else $error("limit flag without capture");
  cover property ($rose(measure_status_out[CMS_ST_LIMIT]));
  cover property ($rose(measure_status_out[CMS_ST_MATCH]));
  cover property ($rose(measure_status_out[CMS_ST_WRAP]));
  cover property ($rose(measure_status_out[CMS_ST_CAPTURE]));
endmodule
bind cms_status cms_status_sva #(.DATA_W(DATA_W)) u_sva (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_in(wr_in), .rd_in(rd_in), .event_input_in(event_input_in),
  .rd_data_out(rd_data_out), .measure_status_out(measure_status_out));
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: self-checking bench for the cycle measurement status block
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes:   tach and external clock come from the partner model
`default_nettype none
module testbench
  import cms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, reset_n_in, wr_in, rd_in, ev, ext, tach_run, ext_lvl;
  logic [2:0]  addr_in;
  logic [15:0] wr_data_in, rd_data_out, d, c1;
  logic [7:0]  st;
  int          n_fail, samples_checked;
  cms_status u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .event_input_in(ev),
    .ext_clock_in(ext), .rd_data_out(rd_data_out), .measure_status_out(st));
  cms_tach_model u_tach (.clk_in(clk_in), .reset_n_in(reset_n_in), .run_in(tach_run),
    .ext_lvl_in(ext_lvl), .event_out(ev), .ext_clk_out(ext));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rd_data_out;
  endtask
  task automatic wait_bit(input int k);
    repeat (400) begin
      @(posedge clk_in);
      #1;
      if (st[k] === 1'b1)
        return;
    end
    chk("wait", 16'h0000, 16'h0001);
    give_verdict();
  endtask
  task automatic clr();
    rd(CMS_OFF_STATUS, d);
    wr(CMS_OFF_STATUS, 16'h0000);
  endtask
  task automatic t_reset();
    chk("status", {8'h00, st}, 16'h0000);
    rd(CMS_OFF_LIMIT, d);
    chk("limit", d, CMS_LIMIT_RST);
    rd(3'h5, d);
    chk("unmapped", d, 16'h0000);
    // ones on the flag bits and the edge select bit, reserved bits stay written as zero
    wr(CMS_OFF_STATUS, 16'h00F8);
    chk("ones", {8'h00, st}, 16'h0010);
    wr(CMS_OFF_STATUS, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_timer();
    wr(CMS_OFF_LIMIT, 16'h0010);
    wr(CMS_OFF_CONTROL, 16'h0040);
    wait_bit(CMS_ST_MATCH);
    tach_run <= 1'b1;
    wait_bit(CMS_ST_CAPTURE);
    tach_run <= 1'b0;
    wr(CMS_OFF_COUNTER, 16'hFFFF);
    wait_bit(CMS_ST_WRAP);
    wr(CMS_OFF_CONTROL, 16'h0000);
    wr(CMS_OFF_STATUS, 16'h0000);
    chk("unarmed", {8'h00, st}, 16'h00A8);
    rd(CMS_OFF_STATUS, d);
    chk("flags", d, 16'h00A8);
    wr(CMS_OFF_STATUS, 16'h0000);
    chk("cleared", {8'h00, st}, 16'h0000);
    $display("timer test done");
  endtask
  task automatic t_speed();
    wr(CMS_OFF_CONTROL, 16'h0001);
    wr(CMS_OFF_LIMIT, 16'hFFFF);
    tach_run <= 1'b1;
    wait_bit(CMS_ST_CAPTURE);
    rd(CMS_OFF_CAPTURE, c1);
    chk("span", 16'((c1 > 16'h0026) && (c1 < 16'h002A)), 16'h0001);
    chk("no limit", {8'h00, st}, 16'h0008);
    clr();
    wr(CMS_OFF_LIMIT, c1);
    wait_bit(CMS_ST_CAPTURE);
    rd(CMS_OFF_CAPTURE, d);
    chk("same span", d, c1);
    chk("equal", {8'h00, st}, 16'h0008);
    clr();
    wr(CMS_OFF_LIMIT, c1 - 16'h0001);
    wait_bit(CMS_ST_CAPTURE);
    chk("over", {8'h00, st}, 16'h0048);
    tach_run <= 1'b0;
    clr();
    $display("speed test done");
  endtask
  task automatic t_ext();
    logic [15:0] exp_cnt [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0002};
    wr(CMS_OFF_CONTROL, 16'h0078);
    wr(CMS_OFF_COUNTER, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      if (i == 2)
        wr(CMS_OFF_STATUS, 16'h0010);
      ext_lvl <= ~ext_lvl;
      repeat (4) @(posedge clk_in);
      rd(CMS_OFF_COUNTER, d);
      chk("ext count", d, exp_cnt[i]);
    end
    $display("external clock test done");
  endtask
  // counter frozen on the quiet external clock, so the capture value is known
  task automatic t_edge();
    wr(CMS_OFF_CONTROL, 16'h007C);
    tach_run <= 1'b1;
    wait_bit(CMS_ST_CAPTURE);
    tach_run <= 1'b0;
    chk("fall edge", {15'h0000, ev}, 16'h0000);
    rd(CMS_OFF_CAPTURE, d);
    chk("capture", d, 16'h0002);
    clr();
    wr(CMS_OFF_CONTROL, 16'h007E);
    tach_run <= 1'b1;
    wait_bit(CMS_ST_CAPTURE);
    tach_run <= 1'b0;
    chk("inverted edge", {15'h0000, ev}, 16'h0001);
    clr();
    $display("edge test done");
  endtask
  // match condition held steady while software clears the flag
  task automatic t_both();
    wr(CMS_OFF_LIMIT, 16'h0002);
    rd(CMS_OFF_STATUS, d);
    chk("match", d, 16'h0020);
    wr(CMS_OFF_STATUS, 16'h0000);
    chk("set wins", {8'h00, st}, 16'h0020);
    wr(CMS_OFF_LIMIT, 16'hFFFF);
    clr();
    chk("clear", {8'h00, st}, 16'h0000);
    $display("set and clear test done");
  endtask
  initial begin
    reset_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 3'h0;
    wr_data_in = 16'h0000;
    tach_run = 1'b0;
    ext_lvl = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_timer();
    t_speed();
    t_ext();
    t_edge();
    t_both();
    give_verdict();
  end
endmodule
`default_nettype wire
